// ---- hw/bsc_pkg.sv ----
package bsc_pkg;
	// Measurement and configuration word width (millivolts).
	localparam int VOLT_W = 16;
	// Threshold fractions in percent of the nominal full-charge voltage.
	localparam logic [7:0] PCT_PAYLOAD_CUT = 8'h4c;
	localparam logic [7:0] PCT_MAIN_CUT = 8'h40;
	localparam logic [7:0] PCT_START = 8'h58;
	localparam logic [7:0] PCT_FULL = 8'h64;
	// Nominal charge current in milliamps, reported to the charger.
	localparam logic [15:0] CC_CURRENT_MA = 16'h04b0;
	// Reset values.
	localparam logic RST_OUT_EN = 1'b0;
	localparam logic RST_CUT = 1'b0;
	localparam logic RST_CHG_CV = 1'b0;
	localparam logic RST_FLAG = 1'b0;
	typedef enum logic [1:0] {
		BSC_WAIT = 2'b00,
		BSC_RUN = 2'b01
	} bsc_state_t;
endpackage

// ---- hw/bsc_sync.sv ----
`timescale 1ns/1ps
module bsc_sync
	import bsc_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic din,
	output logic dout
);
	logic s1;
	logic s2;
	logic s3;

	// Three-stage synchroniser; the output moves only when stages two and three agree.
	always_ff @(posedge mclk) begin
		if (srst) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				dout <= s3;
			end
		end
	end
endmodule

// ---- hw/bsc_supervisor.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Payload output off when battery voltage falls below 76 percent of nominal.
// - Avionics and servo outputs off below 64 percent of nominal.
// - Cut-outs apply only while batteries are the sole power source.
// - With two batteries, a cut-out needs both batteries below its threshold.
// - Starting from batteries alone, all outputs stay off until 88 percent reached.
// - With two batteries, either one meeting the start threshold suffices.
// - Charger runs constant current near 1.2 A while below nominal voltage.
// - Charger switches to constant voltage once nominal voltage is reached.
// - Battery channels are measured and charged fully independently.
// - Cut-out is separate from payload shedding, which follows only generation loss.
// - Hardware shutdown input forces its output off regardless of commands.
module bsc_supervisor
	import bsc_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [VOLT_W-1:0] nominal_mv,
	input wire logic [VOLT_W-1:0] bat_a_mv,
	input wire logic [VOLT_W-1:0] bat_b_mv,
	input wire logic bat_a_present,
	input wire logic bat_b_present,
	input wire logic gen_present,
	input wire logic umb_present,
	input wire logic shed_enable,
	input wire logic cmd_avionics_en,
	input wire logic cmd_servo_en,
	input wire logic cmd_payload_en,
	input wire logic avionics_shdn_n,
	input wire logic servo_shdn_n,
	input wire logic payload_shdn_n,
	output logic avionics_en,
	output logic servo_en,
	output logic payload_en,
	output logic chg_a_cv,
	output logic chg_b_cv,
	output logic [15:0] chg_current_ma,
	output logic payload_cut,
	output logic main_cut,
	output logic start_ok
);
	////////////////////////////////////////////////////////////////////////////////
	// Threshold arithmetic.

	// Scales the nominal voltage by a percentage.
	function automatic logic [VOLT_W-1:0] pct_of(input logic [VOLT_W-1:0] v, input logic [7:0] p);
		logic [VOLT_W+7:0] prod;
		prod = (VOLT_W+8)'(v) * (VOLT_W+8)'(p);
		return VOLT_W'(prod / (VOLT_W+8)'(100));
	endfunction

	// A missing battery counts as below any threshold for cut-out voting.
	function automatic logic below(input logic present, input logic [VOLT_W-1:0] v, input logic [VOLT_W-1:0] th);
		return !present || (v < th);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation of pins.

	logic [7:0] raw_pins;
	logic [7:0] sync_pins;
	assign raw_pins = {bat_a_present, bat_b_present, gen_present, umb_present, shed_enable,
		avionics_shdn_n, servo_shdn_n, payload_shdn_n};

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sync
			bsc_sync bsc_sync_i (
				.mclk(mclk),
				.srst(srst),
				.din(raw_pins[gi]),
				.dout(sync_pins[gi])
			);
		end
	endgenerate

	wire s_bat_a = sync_pins[7];
	wire s_bat_b = sync_pins[6];
	wire s_gen = sync_pins[5];
	wire s_umb = sync_pins[4];
	wire s_shed = sync_pins[3];
	wire s_avi_shdn_n = sync_pins[2];
	wire s_srv_shdn_n = sync_pins[1];
	wire s_pay_shdn_n = sync_pins[0];

	////////////////////////////////////////////////////////////////////////////////
	// Decisions.

	logic [VOLT_W-1:0] th_pay;
	logic [VOLT_W-1:0] th_main;
	logic [VOLT_W-1:0] th_start;
	logic [VOLT_W-1:0] th_full;
	assign th_pay = pct_of(nominal_mv, PCT_PAYLOAD_CUT);
	assign th_main = pct_of(nominal_mv, PCT_MAIN_CUT);
	assign th_start = pct_of(nominal_mv, PCT_START);
	assign th_full = pct_of(nominal_mv, PCT_FULL);

	wire ext_src = s_gen || s_umb;
	wire any_bat = s_bat_a || s_bat_b;
	wire bat_only = !ext_src && any_bat;

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel comparisons; channel 0 is battery A and channel 1 is battery B.

	logic [1:0] ch_present;
	logic [1:0][VOLT_W-1:0] ch_mv;
	logic [1:0] ch_below_pay;
	logic [1:0] ch_below_main;
	logic [1:0] ch_start;
	logic [1:0] ch_full;
	assign ch_present = {s_bat_b, s_bat_a};
	assign ch_mv = {bat_b_mv, bat_a_mv};

	genvar ci;
	generate
		for (ci = 0; ci < 2; ci++) begin : g_chan
			assign ch_below_pay[ci] = below(ch_present[ci], ch_mv[ci], th_pay);
			assign ch_below_main[ci] = below(ch_present[ci], ch_mv[ci], th_main);
			assign ch_start[ci] = ch_present[ci] && (ch_mv[ci] >= th_start);
			assign ch_full[ci] = (ch_mv[ci] >= th_full);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Cut-out voting and latching.

	wire pay_low = any_bat && (&ch_below_pay);
	wire main_low = any_bat && (&ch_below_main);
	wire pay_trip = bat_only && pay_low;
	wire main_trip = bat_only && main_low;
	wire next_payload_cut = ext_src ? 1'b0 : (payload_cut || pay_trip);
	wire next_main_cut = ext_src ? 1'b0 : (main_cut || main_trip);

	////////////////////////////////////////////////////////////////////////////////
	// Start-up gate.

	wire start_met = |ch_start;
	bsc_state_t state;
	bsc_state_t next_state;
	always_comb begin
		case (state)
			BSC_WAIT: begin
				next_state = (ext_src || start_met) ? BSC_RUN : BSC_WAIT;
			end
			BSC_RUN: begin
				next_state = BSC_RUN;
			end
			default: begin
				next_state = BSC_WAIT;
			end
		endcase
	end
	wire running = (state == BSC_RUN);
	wire next_start_ok = running || (next_state == BSC_RUN);

	////////////////////////////////////////////////////////////////////////////////
	// Shedding follows loss of generation only, never battery level.

	logic gen_seen;
	wire next_gen_seen = gen_seen || s_gen;
	wire shed_now = s_shed && gen_seen && !s_gen;

	////////////////////////////////////////////////////////////////////////////////
	// Output enables need the run state, the command, a released shutdown pin and no cut-out.

	wire avi_block = !s_avi_shdn_n || next_main_cut;
	wire srv_block = !s_srv_shdn_n || next_main_cut;
	wire pay_block = !s_pay_shdn_n || next_payload_cut || shed_now;
	wire next_avi = running && cmd_avionics_en && !avi_block;
	wire next_srv = running && cmd_servo_en && !srv_block;
	wire next_pay = running && cmd_payload_en && !pay_block;

	////////////////////////////////////////////////////////////////////////////////
	// Each charger looks only at its own battery.

	wire next_cv_a = ch_full[0];
	wire next_cv_b = ch_full[1];

	////////////////////////////////////////////////////////////////////////////////
	// State registers.

	always_ff @(posedge mclk) begin
		if (srst) begin
			state <= BSC_WAIT;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			payload_cut <= RST_CUT;
			main_cut <= RST_CUT;
		end else begin
			payload_cut <= next_payload_cut;
			main_cut <= next_main_cut;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			gen_seen <= RST_FLAG;
			start_ok <= RST_FLAG;
		end else begin
			gen_seen <= next_gen_seen;
			start_ok <= next_start_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Output registers.

	always_ff @(posedge mclk) begin
		if (srst) begin
			avionics_en <= RST_OUT_EN;
			servo_en <= RST_OUT_EN;
			payload_en <= RST_OUT_EN;
		end else begin
			avionics_en <= next_avi;
			servo_en <= next_srv;
			payload_en <= next_pay;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			chg_a_cv <= RST_CHG_CV;
			chg_b_cv <= RST_CHG_CV;
			chg_current_ma <= CC_CURRENT_MA;
		end else begin
			chg_a_cv <= next_cv_a;
			chg_b_cv <= next_cv_b;
			chg_current_ma <= CC_CURRENT_MA;
		end
	end
endmodule

// ---- testbench/bsc_bat_model.sv ----
`timescale 1ns/1ps
module bsc_bat_model
	import bsc_pkg::*;
(
	input wire logic mclk,
	input wire logic [VOLT_W-1:0] set_a,
	input wire logic [VOLT_W-1:0] set_b,
	output logic [VOLT_W-1:0] bat_a_mv,
	output logic [VOLT_W-1:0] bat_b_mv
);
	// Each measurement channel settles one clock after its set value moves.
	always_ff @(posedge mclk) begin
		bat_a_mv <= set_a;
		bat_b_mv <= set_b;
	end
endmodule

// ---- testbench/bsc_supervisor_props.sv ----
`timescale 1ns/1ps
module bsc_chk
	import bsc_pkg::*;
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [VOLT_W-1:0] nominal_mv,
	input wire logic [VOLT_W-1:0] bat_a_mv,
	input wire logic gen_present,
	input wire logic umb_present,
	input wire logic avionics_shdn_n,
	input logic avionics_en,
	input logic servo_en,
	input logic payload_en,
	input logic chg_a_cv,
	input logic [15:0] chg_current_ma,
	input logic payload_cut,
	input logic main_cut,
	input logic start_ok
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	AST_PAY_OFF: assert property (payload_cut |-> !payload_en) else $error("payload on while cut");
	AST_MAIN_OFF: assert property (main_cut |-> !avionics_en && !servo_en) else $error("main on while cut");
	AST_EXT_INH: assert property ((gen_present || umb_present)[*6] |-> !payload_cut && !main_cut) else $error("cut with source");
	AST_SHDN: assert property ((!avionics_shdn_n)[*6] |-> !avionics_en) else $error("shutdown ignored");
	AST_WAIT_OFF: assert property (!start_ok |-> !payload_en && !avionics_en && !servo_en) else $error("on before start");
	AST_RUN_HOLD: assert property (start_ok |=> start_ok) else $error("start lost");
	AST_LATCH: assert property ((!gen_present && !umb_present)[*6] ##0 payload_cut |=> payload_cut) else $error("cut released");
	AST_CC: assert property (chg_current_ma == CC_CURRENT_MA) else $error("charge current wrong");
	AST_CV: assert property (!$past(srst) |-> chg_a_cv == ($past(bat_a_mv) >= $past(nominal_mv))) else $error("charger mode wrong");
	C_CUT: cover property (payload_cut);
	C_MAIN: cover property (main_cut);
	C_CV: cover property (chg_a_cv);
endmodule
bind bsc_supervisor bsc_chk bsc_chk_i (.*);

// ---- testbench/battery_supervisor_cutout_tb.sv ----
`timescale 1ns/1ps
module battery_supervisor_cutout_tb;
	import bsc_pkg::*;
	logic mclk = 0, srst = 1, pa = 1, pb = 0, gen = 0, umb = 0, shed = 0, avi_n = 1, pay_n = 1;
	logic [15:0] sa = 16'h4e20, sb = 16'h0000, ba, bb;
	logic av, sv, py, cva, cvb, pcut, mcut, sok;
	int n_fail = 0, samples_checked = 0;
	initial forever #50 mclk = ~mclk;
	bsc_bat_model bsc_bat_model_i (.mclk(mclk), .set_a(sa), .set_b(sb), .bat_a_mv(ba), .bat_b_mv(bb));
	bsc_supervisor bsc_supervisor_i (.mclk(mclk), .srst(srst), .nominal_mv(16'h6270), .bat_a_mv(ba), .bat_b_mv(bb),
		.bat_a_present(pa), .bat_b_present(pb), .gen_present(gen), .umb_present(umb), .shed_enable(shed),
		.cmd_avionics_en(1'b1), .cmd_servo_en(1'b1), .cmd_payload_en(1'b1), .avionics_shdn_n(avi_n),
		.servo_shdn_n(1'b1), .payload_shdn_n(pay_n), .avionics_en(av), .servo_en(sv), .payload_en(py),
		.chg_a_cv(cva), .chg_b_cv(cvb), .chg_current_ma(), .payload_cut(pcut), .main_cut(mcut), .start_ok(sok));
	task automatic w(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic chk(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_start();
		w(8);
		chk("start_ok", 1'b0, sok);
		chk("avionics_en", 1'b0, av);
		@(posedge mclk);
		pb <= 1;
		sb <= 16'h56a0;
		w(8);
		chk("start_ok", 1'b1, sok);
		chk("avionics_en", 1'b1, av);
		$display("done start");
	endtask
	task automatic t_cut();
		@(posedge mclk);
		sa <= 16'h4a38;
		sb <= 16'h59d8;
		w(8);
		chk("payload_en", 1'b1, py);
		@(posedge mclk);
		sb <= 16'h4acf;
		w(8);
		chk("payload_en", 1'b0, py);
		@(posedge mclk);
		sa <= 16'h59d8;
		sb <= 16'h59d8;
		w(8);
		chk("payload_en", 1'b0, py);
		chk("servo_en", 1'b1, sv);
		@(posedge mclk);
		sa <= 16'h3eff;
		sb <= 16'h3eff;
		w(8);
		chk("avionics_en", 1'b0, av);
		chk("servo_en", 1'b0, sv);
		@(posedge mclk);
		gen <= 1;
		w(8);
		chk("main_cut", 1'b0, mcut);
		chk("payload_en", 1'b1, py);
		$display("done cut");
	endtask
	task automatic t_cv();
		@(posedge mclk);
		sa <= 16'h6270;
		sb <= 16'h626f;
		w(3);
		chk("chg_a_cv", 1'b1, cva);
		chk("chg_b_cv", 1'b0, cvb);
		@(posedge mclk);
		pay_n <= 0;
		w(8);
		chk("payload_en", 1'b0, py);
		chk("avionics_en", 1'b1, av);
		$display("done cv and shutdown");
	endtask
	task automatic t_ext();
		@(posedge mclk);
		pay_n <= 1;
		shed <= 1;
		umb <= 1;
		w(8);
		chk("payload_en", 1'b1, py);
		@(posedge mclk);
		gen <= 0;
		w(8);
		chk("payload_en", 1'b0, py);
		chk("avionics_en", 1'b1, av);
		@(posedge mclk);
		sa <= 16'h3a98;
		sb <= 16'h3a98;
		w(8);
		chk("main_cut", 1'b0, mcut);
		chk("servo_en", 1'b1, sv);
		@(posedge mclk);
		umb <= 0;
		shed <= 0;
		w(8);
		chk("main_cut", 1'b1, mcut);
		chk("payload_cut", 1'b1, pcut);
		chk("servo_en", 1'b0, sv);
		$display("done external sources and shedding");
	endtask
	task automatic t_reset();
		@(posedge mclk);
		srst <= 1;
		w(2);
		chk("payload_cut", 1'b0, pcut);
		chk("main_cut", 1'b0, mcut);
		chk("start_ok", 1'b0, sok);
		@(posedge mclk);
		srst <= 0;
		w(8);
		chk("start_ok", 1'b0, sok);
		chk("servo_en", 1'b0, sv);
		$display("done mid-run reset");
	endtask
	task automatic t_shdn();
		@(posedge mclk);
		umb <= 1;
		w(8);
		chk("start_ok", 1'b1, sok);
		chk("main_cut", 1'b0, mcut);
		chk("avionics_en", 1'b1, av);
		@(posedge mclk);
		avi_n <= 0;
		w(8);
		chk("avionics_en", 1'b0, av);
		chk("servo_en", 1'b1, sv);
		@(posedge mclk);
		avi_n <= 1;
		w(8);
		chk("avionics_en", 1'b1, av);
		$display("done avionics shutdown");
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 0;
		t_start();
		t_cut();
		t_cv();
		t_ext();
		t_reset();
		t_shdn();
		give_verdict();
	end
	initial begin
		repeat (1000) @(posedge mclk);
		n_fail++;
		give_verdict();
	end
endmodule
